// file: design/mrc_pkg.sv
// Constants and types shared by the remap, decode and reset-cause block.
// Assumes a 200 MHz core clock; all addresses are byte addresses.
package mrc_pkg;

   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam logic [31:0] ADDR_REMAP_CTRL  = 32'hFFFF0220;
   localparam logic [31:0] ADDR_RST_STATUS  = 32'hFFFF0230;
   localparam logic [31:0] ADDR_RST_CLEAR   = 32'hFFFF0234;
   localparam int          REMAP_BIT        = 0;
   localparam int          RST_POR_BIT      = 0;
   localparam int          RST_WDT_BIT      = 1;
   localparam int          RST_SW_BIT       = 2;
   localparam int          RST_EXT_BIT      = 3;
   localparam logic [7:0]  RST_USED_MASK    = 8'h0F;
   localparam logic [7:0]  RST_POR_VALUE    = 8'h01;
   localparam logic [1:0]  AXI_OKAY         = 2'h0;
   localparam logic [1:0]  AXI_SLVERR       = 2'h2;

   // ------------------------------------------------------------------
   // Memory map
   // ------------------------------------------------------------------
   localparam logic [31:0] LOW_WIN_BYTES    = 32'h00017800;
   localparam logic [31:0] SRAM_BASE        = 32'h00040000;
   localparam logic [31:0] SRAM_BYTES       = 32'h00001800;
   localparam int          SRAM_WORDS       = 1536;
   localparam int          SRAM_AW          = 11;
   localparam logic [31:0] FLASH_BASE       = 32'h00080000;
   localparam logic [31:0] FLASH_BYTES      = 32'h00018000;
   localparam logic [19:0] MMR_PAGE         = 20'hFFFF0;

   // ------------------------------------------------------------------
   // Boot check
   // ------------------------------------------------------------------
   localparam logic [6:0]  VEC_KEY_INDEX    = 7'h05;
   localparam logic [31:0] VEC_KEY          = 32'h27011970;
   localparam logic [6:0]  PAGE0_LAST       = 7'h7F;
   localparam int          CLK_PERIOD_NS    = 5;
   localparam int          CFG_TIME_NS      = 1000;
   localparam int          CFG_CYCLES_I     =
      (CFG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0]  CFG_CYCLES       = CFG_CYCLES_I[7:0];

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [0:0] {TGT_FLASH, TGT_PERIPH} mrc_tgt_t;
   typedef enum {
      S_CFG, S_BOOT_RD, S_BOOT_WT, S_CHECK, S_DOWNLOAD,
      S_IDLE, S_SRAM, S_EXT
   } mrc_state_t;

endpackage

// file: design/mrc_sram.sv
// Word-wide SRAM with per-byte write enables and a registered read port.
// Assumes one access per cycle from a single owner on the same clock.
`timescale 1ns/1ps
module mrc_sram
   import mrc_pkg::*;
(
   // Clock
   input  wire logic               aclk,
   // Access
   input  wire logic               en,
   input  wire logic               we,
   input  wire logic [3:0]         be,
   input  wire logic [SRAM_AW-1:0] addr,
   input  wire logic [31:0]        wdata,
   output logic      [31:0]        rdata_r
);

   logic [31:0] mem [0:SRAM_WORDS-1];

   // Only addressed lanes change on narrow writes; one process owns mem
   always_ff @(posedge aclk) begin
      if (en) begin
         for (int i = 0; i < 4; i++) begin
            if (we && be[i]) begin
               mem[addr][8*i +: 8] <= wdata[8*i +: 8];
            end
         end
         rdata_r <= mem[addr];
      end
   end

endmodule // mrc_sram

// file: design/mrc_top.sv
// Address decode, remap control, boot vector check and reset-cause record.
// Assumes a core that holds its request until acknowledged, flash and
// peripheral targets answering on the ext port, and reset logic on aclk.
//
// Function
// - Remap bit set puts SRAM at address zero, clear puts flash there.
// - Any reset clears the remap bit, returning flash to address zero.
// - Lowest 94 kB form the remappable window for flash or SRAM.
// - 4 kB register page at 0xFFFF0000 is decoded and routed to peripherals.
// - Accesses outside every defined region return a data abort.
// - Multi-byte data is little-endian: low byte at lowest address.
// - SRAM is 1536 words at its base, one access per core step.
// - SRAM takes byte, halfword and word accesses, writing only those lanes.
// - After reset, run configuration then release core to vector zero.
// - Word 0x14 must hold key or page checksum, else download mode.
// - Reset-cause status keeps every reset source seen since power-on or the last clear.
// - Power-on sets bit 0, watchdog bit 1, external reset bit 3.
// - Writing 1 to status bit 2 causes and records a software reset.
// - Writing 1 to a clear-register bit clears that status bit.
// - Status bits 7 to 4 always read zero.
// - Clear write leaving set software bit uncleared resets again.
// - Resets restore defaults except the recorded cause bits.
`timescale 1ns/1ps
module mrc_top
   import mrc_pkg::*;
(
   // Clock and resets
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        por_rstn,
   // Reset cause events
   input  wire logic        wdt_rst_evt,
   input  wire logic        ext_rst_evt,
   output logic             sw_reset_r,
   // AXI4-Lite slave
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Core access port
   input  wire logic        core_req,
   input  wire logic        core_we,
   input  wire logic [1:0]  core_size,
   input  wire logic [31:0] core_addr,
   input  wire logic [31:0] core_wdata,
   output logic             core_ack_r,
   output logic             core_abort_r,
   output logic [31:0]      core_rdata_r,
   // Flash and peripheral target port
   output logic             ext_req_r,
   output logic             ext_tgt_r,
   output logic             ext_we_r,
   output logic [31:0]      ext_addr_r,
   output logic [3:0]       ext_be_r,
   output logic [31:0]      ext_wdata_r,
   input  wire logic        ext_ack,
   input  wire logic [31:0] ext_rdata,
   // Boot outcome
   output logic             core_run_r,
   output logic             download_mode_r
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   mrc_state_t        state_r;
   logic [7:0]        cfg_cnt_r;
   logic [6:0]        boot_idx_r;
   logic [31:0]       sum_r;
   logic [31:0]       key_word_r;
   logic              remap_r;
   logic [7:0]        status_r;
   logic [7:0]        status_nxt;
   logic [1:0]        lane_r;
   logic [31:0]       sram_rdata;
   logic              rst_any;

   assign rst_any = !aresetn || !por_rstn;

   // ------------------------------------------------------------------
   // Core address decode
   // ------------------------------------------------------------------
   wire low_hit    = core_addr < LOW_WIN_BYTES;
   wire low_sram   = low_hit && remap_r && core_addr < SRAM_BYTES;
   wire low_flash  = low_hit && !remap_r;
   wire sram_abs   = core_addr >= SRAM_BASE &&
                     core_addr < SRAM_BASE + SRAM_BYTES;
   wire flash_abs  = core_addr >= FLASH_BASE &&
                     core_addr < FLASH_BASE + FLASH_BYTES;
   wire mmr_hit    = core_addr[31:12] == MMR_PAGE;
   wire sram_hit   = sram_abs || low_sram;
   wire flash_hit  = flash_abs || low_flash;
   wire misalign   = core_size == 2'd3 ||
                     (core_size == 2'd1 && core_addr[0]) ||
                     (core_size == 2'd2 && core_addr[1:0] != 2'd0);
   wire undefined  = !(sram_hit || flash_hit || mmr_hit) || misalign;
   wire take       = state_r == S_IDLE && core_req && !core_ack_r;
   wire [31:0] flash_addr = low_flash ? core_addr + FLASH_BASE
                                      : core_addr;
   // Little-endian lanes: byte n of a word sits at address offset n
   wire [3:0]  core_be =
      core_size == 2'd0 ? 4'h1 << core_addr[1:0] :
      core_size == 2'd1 ? 4'h3 << {core_addr[1], 1'b0} : 4'hF;
   wire [31:0] lane_wdata = core_wdata << {core_addr[1:0], 3'b000};
   wire        mem_en  = take && sram_hit && !undefined;
   wire [31:0] sram_rd_shift = sram_rdata >> {lane_r, 3'b000};
   wire [31:0] ext_rd_shift  = ext_rdata >> {lane_r, 3'b000};

   // SRAM base and window alias share address bits 12:2
   mrc_sram u_sram (
      .aclk    (aclk),
      .en      (mem_en),
      .we      (core_we),
      .be      (core_be),
      .addr    (core_addr[12:2]),
      .wdata   (lane_wdata),
      .rdata_r (sram_rdata)
   );

   // ------------------------------------------------------------------
   // Boot check and core access sequencer
   // ------------------------------------------------------------------
   wire key_ok = key_word_r == VEC_KEY || key_word_r == sum_r;

   always_ff @(posedge aclk) begin
      if (rst_any) begin
         state_r         <= S_CFG;
         cfg_cnt_r       <= 8'h00;
         boot_idx_r      <= 7'h00;
         sum_r           <= 32'h00000000;
         key_word_r      <= 32'h00000000;
         lane_r          <= 2'h0;
         core_ack_r      <= 1'b0;
         core_abort_r    <= 1'b0;
         core_rdata_r    <= 32'h00000000;
         ext_req_r       <= 1'b0;
         ext_tgt_r       <= TGT_FLASH;
         ext_we_r        <= 1'b0;
         ext_addr_r      <= 32'h00000000;
         ext_be_r        <= 4'h0;
         ext_wdata_r     <= 32'h00000000;
         core_run_r      <= 1'b0;
         download_mode_r <= 1'b0;
      end else begin
         core_ack_r   <= 1'b0;
         core_abort_r <= 1'b0;
         case (state_r)
            S_CFG: begin
               cfg_cnt_r <= cfg_cnt_r + 8'h01;
               if (cfg_cnt_r == CFG_CYCLES - 8'h01) begin
                  state_r <= S_BOOT_RD;
               end
            end
            S_BOOT_RD: begin
               ext_req_r  <= 1'b1;
               ext_tgt_r  <= TGT_FLASH;
               ext_we_r   <= 1'b0;
               ext_be_r   <= 4'hF;
               ext_addr_r <= FLASH_BASE + {23'h0, boot_idx_r, 2'b00};
               state_r    <= S_BOOT_WT;
            end
            S_BOOT_WT: begin
               if (ext_ack) begin
                  ext_req_r  <= 1'b0;
                  boot_idx_r <= boot_idx_r + 7'h01;
                  // Key word itself is left out of the checksum
                  if (boot_idx_r == VEC_KEY_INDEX) begin
                     key_word_r <= ext_rdata;
                  end else begin
                     sum_r <= sum_r + ext_rdata;
                  end
                  state_r <= boot_idx_r == PAGE0_LAST ? S_CHECK
                                                      : S_BOOT_RD;
               end
            end
            S_CHECK: begin
               core_run_r      <= key_ok;
               download_mode_r <= !key_ok;
               state_r         <= key_ok ? S_IDLE : S_DOWNLOAD;
            end
            S_DOWNLOAD: begin
               state_r <= S_DOWNLOAD;
            end
            S_IDLE: begin
               if (take) begin
                  lane_r <= core_addr[1:0];
                  if (undefined) begin
                     core_ack_r   <= 1'b1;
                     core_abort_r <= 1'b1;
                     core_rdata_r <= 32'h00000000;
                  end else if (sram_hit) begin
                     state_r <= S_SRAM;
                  end else begin
                     ext_req_r   <= 1'b1;
                     ext_tgt_r   <= mmr_hit ? TGT_PERIPH : TGT_FLASH;
                     ext_we_r    <= core_we;
                     ext_be_r    <= core_be;
                     ext_wdata_r <= lane_wdata;
                     ext_addr_r  <= mmr_hit ? core_addr : flash_addr;
                     state_r     <= S_EXT;
                  end
               end
            end
            S_SRAM: begin
               core_ack_r   <= 1'b1;
               core_rdata_r <= sram_rd_shift;
               state_r      <= S_IDLE;
            end
            S_EXT: begin
               if (ext_ack) begin
                  ext_req_r    <= 1'b0;
                  core_ack_r   <= 1'b1;
                  core_rdata_r <= ext_rd_shift;
                  state_r      <= S_IDLE;
               end
            end
            default: state_r <= S_CFG;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // AXI4-Lite register slave
   // ------------------------------------------------------------------
   logic [31:0] awaddr_r;
   logic [31:0] wdata_r;
   logic        wstrb0_r;

   wire wr_do     = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   wire wr_lane   = wr_do && wstrb0_r;
   wire wr_remap  = wr_lane && awaddr_r == ADDR_REMAP_CTRL;
   wire wr_status = wr_lane && awaddr_r == ADDR_RST_STATUS;
   wire wr_clear  = wr_lane && awaddr_r == ADDR_RST_CLEAR;
   wire wr_mapped = awaddr_r == ADDR_REMAP_CTRL ||
                    awaddr_r == ADDR_RST_STATUS ||
                    awaddr_r == ADDR_RST_CLEAR;
   wire rd_take   = s_axi_arvalid && s_axi_arready;
   wire rd_remap  = s_axi_araddr == ADDR_REMAP_CTRL;
   wire rd_status = s_axi_araddr == ADDR_RST_STATUS;
   wire rd_clear  = s_axi_araddr == ADDR_RST_CLEAR;
   // Clear register is write-only and reads back zero
   wire [31:0] rd_word = rd_remap  ? {31'h0, remap_r} :
                         rd_status ? {24'h0, status_r} : 32'h00000000;

   always_ff @(posedge aclk) begin
      if (rst_any) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= AXI_OKAY;
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= AXI_OKAY;
         awaddr_r      <= 32'h00000000;
         wdata_r       <= 32'h00000000;
         wstrb0_r      <= 1'b0;
         remap_r       <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_r      <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_r      <= s_axi_wdata;
            wstrb0_r     <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end
         if (wr_do) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? AXI_OKAY : AXI_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
         // Reserved bits 31:1 are not stored, so they read as zero
         if (wr_remap) begin
            remap_r <= wdata_r[REMAP_BIT];
         end
         if (rd_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= (rd_remap || rd_status || rd_clear)
                             ? AXI_OKAY : AXI_SLVERR;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------
   // Reset cause record
   // ------------------------------------------------------------------
   // Survives aresetn; only power-on restarts it, so the cause is kept
   wire       sw_set  = (wr_status && wdata_r[RST_SW_BIT]) ||
                        (wr_clear && status_r[RST_SW_BIT] &&
                         !wdata_r[RST_SW_BIT]);
   wire [7:0] set_vec = {4'h0, ext_rst_evt, sw_set, wdt_rst_evt, 1'b0};
   wire [7:0] clr_vec = wr_clear ? wdata_r[7:0] : 8'h00;

   // Set wins over a clear landing in the same cycle
   assign status_nxt = ((status_r & ~clr_vec) | set_vec)
                       & RST_USED_MASK;

   always_ff @(posedge aclk) begin
      if (!por_rstn) begin
         status_r   <= RST_POR_VALUE;
         sw_reset_r <= 1'b0;
      end else begin
         status_r   <= status_nxt;
         sw_reset_r <= sw_set;
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (rst_any);

   a_remap_sram_low: assert property (take && low_sram && !misalign
      |=> state_r == S_SRAM ##1 core_ack_r && !core_abort_r)
      else $error("low window with remap set did not reach SRAM");
   a_remap_flash_low: assert property (take && low_flash && !misalign
      |=> ext_req_r && ext_addr_r == $past(core_addr) + FLASH_BASE)
      else $error("low window with remap clear did not reach flash");
   a_remap_reset_clr: assert property (@(posedge aclk) disable iff (1'b0)
      !aresetn |=> !remap_r)
      else $error("remap bit survived reset");
   a_mmr_route_periph: assert property (take && mmr_hit && !misalign
      |=> ext_req_r && ext_tgt_r == TGT_PERIPH)
      else $error("register page access not routed to peripherals");
   a_undef_data_abort: assert property (take && undefined
      |=> core_ack_r && core_abort_r && state_r == S_IDLE)
      else $error("undefined access did not abort");
   a_sram_byte_lane: assert property (mem_en && core_size == 2'd0
      |-> $onehot(core_be) && core_be[core_addr[1:0]])
      else $error("byte write enables wrong lane");
   a_boot_key_run: assert property (state_r == S_CHECK && key_ok
      |=> core_run_r && !download_mode_r)
      else $error("valid vector key did not release core");
   a_boot_bad_dl: assert property (state_r == S_CHECK && !key_ok
      |=> download_mode_r && !core_run_r)
      else $error("bad vector key did not enter download mode");
   a_sw_reset_rec: assert property (wr_status && wdata_r[RST_SW_BIT]
      |=> sw_reset_r && status_r[RST_SW_BIT])
      else $error("software reset not raised or recorded");
   a_sw_retrigger: assert property (wr_clear && status_r[RST_SW_BIT]
      && !wdata_r[RST_SW_BIT] |=> sw_reset_r)
      else $error("clear write left software bit but no reset");
   a_clear_bit_one: assert property (wr_clear && wdata_r[RST_WDT_BIT]
      && !wdt_rst_evt |=> !status_r[RST_WDT_BIT])
      else $error("clear write did not clear watchdog bit");
   a_set_beats_clr: assert property (wdt_rst_evt || ext_rst_evt
      |=> (status_r[RST_WDT_BIT] || !$past(wdt_rst_evt))
      && (status_r[RST_EXT_BIT] || !$past(ext_rst_evt)))
      else $error("hardware cause lost against clear");
   a_unused_zero: assert property (status_r[7:4] == 4'h0 [*2])
      else $error("unused status bits not zero");

   c_boot_pass:  cover property (state_r == S_CHECK ##1 core_run_r);
   c_boot_dl:    cover property (state_r == S_CHECK ##1 download_mode_r);
   c_sram_remap: cover property (take && low_sram ##2 core_ack_r);
   c_sw_reset:   cover property (sw_reset_r);

endmodule // mrc_top

// file: bench/mrc_ext_model.sv
// Behavioural flash and register-page target on the ext port.
// Assumes one outstanding request, held until ack, on aclk.
`timescale 1ns/1ps
module mrc_ext_model
   import mrc_pkg::*;
(
   // Target side
   input  wire logic        aclk,
   input  wire logic        ext_req_r,
   input  wire logic [31:0] ext_addr_r,
   output logic             ext_ack,
   output logic [31:0]      ext_rdata
);
   int wait_n = 0;
   // Set by the bench to spoil the boot key word
   bit key_bad = 1'b0;
   initial begin
      ext_ack = 1'b0;
      ext_rdata = 32'h0;
   end
   // --------------------------------------------------------------
   // Answer after 0 to 3 idle cycles
   // --------------------------------------------------------------
   always @(posedge aclk) begin
      ext_ack <= 1'b0;
      // Released data does not hold its last value
      ext_rdata <= ~ext_rdata;
      if (ext_req_r && !ext_ack) begin
         if (wait_n == 0) begin
            ext_ack <= 1'b1;
            // Boot word carries the key, others an address pattern
            ext_rdata <= (ext_addr_r == FLASH_BASE + 32'h14) ?
               (key_bad ? ~VEC_KEY : VEC_KEY) :
               {ext_addr_r[15:0], ~ext_addr_r[15:0]};
            wait_n <= $urandom % 4;
         end else
            wait_n <= wait_n - 1;
      end
   end
endmodule // mrc_ext_model

// file: bench/mrc_top_tb.sv
// Self-checking bench for mrc_top with an ext target model.
// Assumes the hand-over timing of the AXI and core ports.
`timescale 1ns/1ps
module mrc_top_tb
   import mrc_pkg::*;
;
   logic        aclk, aresetn, por_rstn, wdt_rst_evt, ext_rst_evt, sw_reset_r;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [31:0] core_addr, core_wdata, core_rdata_r, ext_addr_r, ext_rdata;
   logic [31:0] ext_wdata_r, rd, m, sa, d;
   logic [3:0]  s_axi_wstrb, ext_be_r;
   logic [1:0]  s_axi_bresp, s_axi_rresp, core_size, rs;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, core_req, core_we, core_ack_r;
   logic        core_abort_r, ext_req_r, ext_tgt_r, ext_we_r, ext_ack, ab;
   logic        core_run_r, download_mode_r;
   logic [31:0] bad [4] = '{32'h1800, 32'h00100000, 32'h00041800, 32'hFFFE0000};
   int          mismatches = 0, cmp_count = 0, sw_cnt = 0, b, h, i, seed_v;
   mrc_top mrc_top_i (.aclk, .aresetn, .por_rstn, .wdt_rst_evt, .ext_rst_evt,
      .sw_reset_r, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .core_req,
      .core_we, .core_size, .core_addr, .core_wdata, .core_ack_r, .core_abort_r,
      .core_rdata_r, .ext_req_r, .ext_tgt_r, .ext_we_r, .ext_addr_r, .ext_be_r,
      .ext_wdata_r, .ext_ack, .ext_rdata, .core_run_r, .download_mode_r);
   mrc_ext_model mrc_ext_model_i (.aclk, .ext_req_r, .ext_addr_r, .ext_ack,
      .ext_rdata);
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   always @(posedge aclk) if (sw_reset_r === 1'b1) sw_cnt <= sw_cnt + 1;
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   function automatic logic [31:0] fexp(input logic [31:0] a);
      return {a[15:0], ~a[15:0]};
   endfunction
   task complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, e);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch at %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic tmo(input int n, lim);
      if (n >= lim) begin
         mismatches++;
         complete_run();
      end
   endtask
   task automatic axi_wr(input logic [31:0] a, dt);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= dt;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 60; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      tmo(n, 60);
      s_axi_bready <= 1'b0;
      rs = s_axi_bresp;
   endtask
   task automatic axi_rd(input logic [31:0] a);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 60; n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      tmo(n, 60);
      s_axi_rready <= 1'b0;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
   endtask
   task automatic core(input logic we, input logic [1:0] sz,
                       input logic [31:0] a, dt);
      int n;
      @(posedge aclk);
      core_we <= we;
      core_size <= sz;
      core_addr <= a;
      core_wdata <= dt;
      core_req <= 1'b1;
      for (n = 0; n < 60; n++) begin
         @(posedge aclk);
         if (core_ack_r) break;
      end
      tmo(n, 60);
      core_req <= 1'b0;
      rd = core_rdata_r;
      ab = core_abort_r;
   endtask
   task automatic do_rst(input logic por);
      int n;
      aresetn <= 1'b0;
      por_rstn <= !por;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      por_rstn <= 1'b1;
      for (n = 0; n < 4000; n++) begin
         @(posedge aclk);
         if (core_run_r || download_mode_r) break;
      end
      tmo(n, 4000);
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {wdt_rst_evt, ext_rst_evt, core_req, core_we, s_axi_awvalid} = 5'h0;
      {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 4'h0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr, core_addr, core_wdata} = '0;
      s_axi_wstrb = 4'hF;
      core_size = 2'h2;
      seed_v = $urandom(97);
      do_rst(1'b1);
      chk({31'h0, download_mode_r}, 32'h0);
      axi_rd(ADDR_RST_STATUS);
      chk(rd, 32'h01);
      axi_rd(ADDR_REMAP_CTRL);
      chk(rd, 32'h0);
      core(1'b0, 2'h2, 32'h100, 32'h0);
      chk(rd, fexp(FLASH_BASE + 32'h100));
      core(1'b0, 2'h2, 32'hFFFF0100, 32'h0);
      chk({31'h0, ab}, 32'h0);
      chk(rd, fexp(32'hFFFF0100));
      for (i = 0; i < 6; i++) begin
         sa = SRAM_BASE + 32'(4 * ($urandom % SRAM_WORDS));
         b = $urandom % 4;
         h = 2 * ($urandom % 2);
         m = $urandom;
         core(1'b1, 2'h2, sa, m);
         d = $urandom;
         core(1'b1, 2'h0, sa + 32'(b), d);
         m[8*b +: 8] = d[7:0];
         d = $urandom;
         core(1'b1, 2'h1, sa + 32'(h), d);
         m[8*h +: 16] = d[15:0];
         core(1'b0, 2'h2, sa, 32'h0);
         chk(rd, m);
         core(1'b0, 2'h0, sa + 32'(b), 32'h0);
         chk(rd, m >> (8 * b));
      end
      axi_wr(ADDR_REMAP_CTRL, 32'h01);
      chk({30'h0, rs}, {30'h0, AXI_OKAY});
      core(1'b0, 2'h2, sa - SRAM_BASE, 32'h0);
      chk(rd, m);
      foreach (bad[k]) begin
         core(1'b0, 2'h2, bad[k], 32'h0);
         chk({31'h0, ab}, 32'h1);
      end
      @(posedge aclk) {wdt_rst_evt, ext_rst_evt} <= 2'b11;
      @(posedge aclk) {wdt_rst_evt, ext_rst_evt} <= 2'b00;
      axi_rd(ADDR_RST_STATUS);
      chk(rd, 32'h0B);
      axi_wr(ADDR_RST_CLEAR, 32'hFF);
      axi_rd(ADDR_RST_STATUS);
      chk(rd, 32'h0);
      axi_wr(ADDR_RST_STATUS, 32'hF4);
      axi_rd(ADDR_RST_STATUS);
      chk(rd, 32'h04);
      chk(32'(sw_cnt), 32'h1);
      axi_wr(ADDR_RST_CLEAR, 32'h01);
      axi_rd(32'hFFFF0300);
      chk({30'h0, rs}, {30'h0, AXI_SLVERR});
      chk(32'(sw_cnt), 32'h2);
      do_rst(1'b0);
      axi_rd(ADDR_REMAP_CTRL);
      chk(rd, 32'h0);
      axi_rd(ADDR_RST_STATUS);
      chk(rd, 32'h04);
      mrc_ext_model_i.key_bad <= 1'b1;
      do_rst(1'b0);
      chk({30'h0, core_run_r, download_mode_r}, 32'h1);
      complete_run();
   end
endmodule // mrc_top_tb
